// ---- design/crba_core.sv ----
// CPU dedicated registers, status word and address generation with Avalon-MM access
//
// Our own choices: the Avalon-MM register port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "crba_defines.svh"

module crba_core
    import crba_pkg::*;
(
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst_n,
    // Avalon-MM register slave
    input  wire logic [10:0]      avs_address,
    input  wire logic             avs_read,
    input  wire logic             avs_write,
    input  wire logic [31:0]      avs_writedata,
    input  wire logic [3:0]       avs_byteenable,
    output logic      [31:0]      avs_readdata,
    output logic                  avs_waitrequest,
    // Decoder register writes and fetch advance
    input  wire crba_reg_wr_type  reg_wr,
    input  wire logic             ip_advance,
    // Arithmetic request on accumulator and temporary accumulator
    input  wire crba_alu_req_type alu_req,
    // Address generation requests
    input  wire logic             gp_req,
    input  wire logic [2:0]       gp_opcode_bits,
    input  wire logic             dir_req,
    input  wire logic [7:0]       dir_addr,
    input  wire logic             idx_req,
    input  wire logic [7:0]       idx_disp,
    // Interrupt request
    input  wire logic             irq_req,
    input  wire logic [1:0]       irq_level,
    // Generated addresses and interrupt take
    output logic      [15:0]      gp_addr,
    output logic                  gp_addr_valid,
    output logic      [15:0]      dir_mapped,
    output logic                  dir_valid,
    output logic      [15:0]      idx_addr,
    output logic                  idx_valid,
    output logic                  irq_take,
    // Register contents toward the decoder
    output logic      [15:0]      instruction_pointer,
    output logic      [15:0]      accumulator,
    output logic      [15:0]      temp_accumulator,
    output logic      [15:0]      index_reg,
    output logic      [15:0]      extra_pointer,
    output logic      [15:0]      stack_pointer,
    output logic      [15:0]      program_status_word
);

    function automatic crba_alu_type crba_alu(
        input logic [15:0]     a,
        input logic [15:0]     b,
        input crba_alu_op_type op,
        input logic            byte_mode,
        input logic            old_h
    );
        logic [16:0]  s;
        logic [8:0]   s8;
        logic [4:0]   h;
        logic         a_msb;
        logic         b_msb;
        logic         r_msb;
        crba_alu_type r;
        begin
            s  = 17'h00000;
            s8 = 9'h000;
            h  = 5'h00;
            r  = '0;
            r.h = old_h;
            unique case (op)
                CRBA_OP_ADD: begin
                    s  = {1'b0, a} + {1'b0, b};
                    s8 = {1'b0, a[7:0]} + {1'b0, b[7:0]};
                    h  = {1'b0, a[3:0]} + {1'b0, b[3:0]};
                end
                CRBA_OP_SUB: begin
                    s  = {1'b0, a} - {1'b0, b};
                    s8 = {1'b0, a[7:0]} - {1'b0, b[7:0]};
                    h  = {1'b0, a[3:0]} - {1'b0, b[3:0]};
                end
                default: ;
            endcase
            // Byte ops touch only the low byte; upper byte is kept
            a_msb = byte_mode ? a[7] : a[15];
            b_msb = byte_mode ? b[7] : b[15];
            unique case (op)
                CRBA_OP_SHL: begin
                    r.res = byte_mode ? {a[15:8], a[6:0], 1'b0} : {a[14:0], 1'b0};
                    r.c   = a_msb;
                end
                CRBA_OP_SHR: begin
                    r.res = byte_mode ? {a[15:8], 1'b0, a[7:1]} : {1'b0, a[15:1]};
                    r.c   = a[0];
                end
                default: begin
                    r.res = byte_mode ? {a[15:8], s8[7:0]} : s[15:0];
                    r.c   = byte_mode ? s8[8] : s[16];
                    r.h   = h[4];
                end
            endcase
            r_msb = byte_mode ? r.res[7] : r.res[15];
            r.n = r_msb;
            r.z = byte_mode ? (r.res[7:0] == 8'h00) : (r.res == 16'h0000);
            unique case (op)
                CRBA_OP_ADD: r.v = (a_msb == b_msb) && (r_msb != a_msb);
                CRBA_OP_SUB: r.v = (a_msb != b_msb) && (r_msb != a_msb);
                default:     r.v = 1'b0;
            endcase
            crba_alu = r;
        end
    endfunction : crba_alu

    // Window base steps by 128 bytes per direct bank value
    function automatic logic [15:0] crba_dir_map(input logic [7:0] addr, input logic [2:0] dbf);
        begin
            if (!addr[7]) begin
                crba_dir_map = {8'h00, addr};
            end else begin
                crba_dir_map = `CRBA_DIR_BASE + {6'h00, dbf, 7'h00} + {9'h000, addr[6:0]};
            end
        end
    endfunction : crba_dir_map

    function automatic logic [15:0] crba_merge(
        input logic [15:0] old,
        input logic [31:0] wdata,
        input logic [3:0]  be
    );
        begin
            crba_merge = {be[1] ? wdata[15:8] : old[15:8], be[0] ? wdata[7:0] : old[7:0]};
        end
    endfunction : crba_merge

    logic [1:0]     rst_sync_ff;
    logic           rst_sync_n;
    crba_state_type st_ff;
    crba_state_type nxt_st;
    crba_alu_type   alu_r;
    logic [8:0]     bus_idx;
    logic [15:0]    psw;
    logic           int_enable;
    logic [1:0]     cur_il;

    assign rst_sync_n = rst_sync_ff[1];
    assign bus_idx    = avs_address[10:2];
    assign psw        = {st_ff.rbp, st_ff.dbf, st_ff.condition_code_byte};
    assign int_enable = st_ff.condition_code_byte[`CRBA_CCR_I];
    assign cur_il     = st_ff.condition_code_byte[`CRBA_CCR_IL_HI:`CRBA_CCR_IL_LO];
    assign alu_r      = crba_alu(st_ff.acc, st_ff.tmp, alu_req.op, alu_req.byte_mode,
                                 st_ff.condition_code_byte[`CRBA_CCR_H]);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end

    always_comb begin
        nxt_st = st_ff;
        // Address generation, all within the 16-bit space
        nxt_st.gp_vld = gp_req;
        if (gp_req) begin
            nxt_st.gp_addr = {`CRBA_GP_PAGE, st_ff.rbp, gp_opcode_bits};
        end
        nxt_st.dir_vld = dir_req;
        if (dir_req) begin
            nxt_st.dir_addr = crba_dir_map(dir_addr, st_ff.dbf);
        end
        nxt_st.idx_vld = idx_req;
        if (idx_req) begin
            nxt_st.idx_addr = st_ff.index + {{8{idx_disp[7]}}, idx_disp};
        end
        // Lower code means higher priority; a level-3 request never wins
        nxt_st.irq_take = irq_req && int_enable && (irq_level < cur_il);
        // Bus slave: one wait cycle, then acknowledge; writes land on the acknowledge edge
        unique case (st_ff.bus)
            CRBA_BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    nxt_st.bus     = CRBA_BUS_ACK;
                    nxt_st.waitreq = 1'b0;
                    nxt_st.rdata   = 32'h00000000;
                    if (avs_read) begin
                        unique case (bus_idx)
                            `CRBA_IDX_IP:     nxt_st.rdata = {16'h0000, st_ff.ip};
                            `CRBA_IDX_ACC:    nxt_st.rdata = {16'h0000, st_ff.acc};
                            `CRBA_IDX_TMP:    nxt_st.rdata = {16'h0000, st_ff.tmp};
                            `CRBA_IDX_INDEX:  nxt_st.rdata = {16'h0000, st_ff.index};
                            `CRBA_IDX_EP:     nxt_st.rdata = {16'h0000, st_ff.ep};
                            `CRBA_IDX_SP:     nxt_st.rdata = {16'h0000, st_ff.sp};
                            `CRBA_IDX_PSW:    nxt_st.rdata = {16'h0000, psw};
                            `CRBA_IDX_MIRROR: nxt_st.rdata = {24'h000000, st_ff.rbp, st_ff.dbf};
                            default:          nxt_st.rdata = 32'h00000000;
                        endcase
                    end
                end
            end
            CRBA_BUS_ACK: begin
                nxt_st.bus     = CRBA_BUS_IDLE;
                nxt_st.waitreq = 1'b1;
                if (avs_write) begin
                    unique case (bus_idx)
                        `CRBA_IDX_IP:    nxt_st.ip    = crba_merge(st_ff.ip, avs_writedata, avs_byteenable);
                        `CRBA_IDX_ACC:   nxt_st.acc   = crba_merge(st_ff.acc, avs_writedata, avs_byteenable);
                        `CRBA_IDX_TMP:   nxt_st.tmp   = crba_merge(st_ff.tmp, avs_writedata, avs_byteenable);
                        `CRBA_IDX_INDEX: nxt_st.index = crba_merge(st_ff.index, avs_writedata, avs_byteenable);
                        `CRBA_IDX_EP:    nxt_st.ep    = crba_merge(st_ff.ep, avs_writedata, avs_byteenable);
                        `CRBA_IDX_SP:    nxt_st.sp    = crba_merge(st_ff.sp, avs_writedata, avs_byteenable);
                        `CRBA_IDX_PSW: begin
                            {nxt_st.rbp, nxt_st.dbf, nxt_st.condition_code_byte} = crba_merge(psw, avs_writedata, avs_byteenable);
                        end
                        `CRBA_IDX_MIRROR: begin
                            if (avs_byteenable[0]) begin
                                {nxt_st.rbp, nxt_st.dbf} = avs_writedata[7:0];
                            end
                        end
                        default: ;
                    endcase
                end
            end
        endcase
        // Core activity overrides a software write in the same cycle
        if (ip_advance) begin
            nxt_st.ip = st_ff.ip + 16'h0001;
        end
        if (alu_req.en) begin
            nxt_st.acc                  = alu_r.res;
            nxt_st.condition_code_byte[`CRBA_CCR_H]     = alu_r.h;
            nxt_st.condition_code_byte[`CRBA_CCR_N]     = alu_r.n;
            nxt_st.condition_code_byte[`CRBA_CCR_Z]     = alu_r.z;
            nxt_st.condition_code_byte[`CRBA_CCR_V]     = alu_r.v;
            nxt_st.condition_code_byte[`CRBA_CCR_C]     = alu_r.c;
        end
        if (reg_wr.en) begin
            unique case (reg_wr.sel)
                CRBA_SEL_IP:    nxt_st.ip    = reg_wr.data;
                CRBA_SEL_ACC:   nxt_st.acc   = reg_wr.data;
                CRBA_SEL_TMP:   nxt_st.tmp   = reg_wr.data;
                CRBA_SEL_INDEX: nxt_st.index = reg_wr.data;
                CRBA_SEL_EP:    nxt_st.ep    = reg_wr.data;
                CRBA_SEL_SP:    nxt_st.sp    = reg_wr.data;
                CRBA_SEL_PSW:   {nxt_st.rbp, nxt_st.dbf, nxt_st.condition_code_byte} = reg_wr.data;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            st_ff          <= '0;
            st_ff.bus      <= CRBA_BUS_IDLE;
            st_ff.waitreq  <= 1'b1;
            st_ff.ip       <= `CRBA_IP_RST;
            // Data registers have no architectural reset; zero keeps simulation clean
            st_ff.acc      <= `CRBA_WORD_RST;
            st_ff.rbp      <= `CRBA_RBP_RST;
            st_ff.dbf      <= `CRBA_DBF_RST;
            st_ff.condition_code_byte      <= `CRBA_CCR_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign avs_readdata        = st_ff.rdata;
    assign avs_waitrequest     = st_ff.waitreq;
    assign gp_addr             = st_ff.gp_addr;
    assign gp_addr_valid       = st_ff.gp_vld;
    assign dir_mapped          = st_ff.dir_addr;
    assign dir_valid           = st_ff.dir_vld;
    assign idx_addr            = st_ff.idx_addr;
    assign idx_valid           = st_ff.idx_vld;
    assign irq_take            = st_ff.irq_take;
    assign instruction_pointer = st_ff.ip;
    assign accumulator         = st_ff.acc;
    assign temp_accumulator    = st_ff.tmp;
    assign index_reg           = st_ff.index;
    assign extra_pointer       = st_ff.ep;
    assign stack_pointer       = st_ff.sp;
    assign program_status_word = psw;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_sync_n);

    a_gp_addr_form: assert property (gp_req |=> gp_addr_valid &&
        gp_addr == {`CRBA_GP_PAGE, $past(st_ff.rbp), $past(gp_opcode_bits)})
        else $error("register bank address malformed");

    a_dir_low_pass: assert property ((dir_req && !dir_addr[7]) |=>
        dir_valid && dir_mapped == {8'h00, $past(dir_addr)})
        else $error("low direct address was remapped");

    a_dir_high_map: assert property ((dir_req && dir_addr[7]) |=>
        dir_mapped >= 16'h0080 && dir_mapped <= 16'h047F && dir_mapped[6:0] == $past(dir_addr[6:0])
        && dir_mapped[9:7] == $past(st_ff.dbf) + 3'h1)
        else $error("direct window mapping wrong");

    a_irq_blocked: assert property (!int_enable |=> !irq_take)
        else $error("interrupt taken while disabled");

    a_irq_level: assert property (irq_take |-> $past(irq_req) && $past(irq_level) < $past(cur_il))
        else $error("interrupt level not above current");

    a_neg_flag: assert property ((alu_req.en && !reg_wr.en && !alu_req.byte_mode) |=>
        st_ff.condition_code_byte[`CRBA_CCR_N] == accumulator[15])
        else $error("negative flag mismatch");

    a_zero_flag: assert property ((alu_req.en && !reg_wr.en && alu_req.byte_mode) |=>
        st_ff.condition_code_byte[`CRBA_CCR_Z] == (accumulator[7:0] == 8'h00))
        else $error("zero flag mismatch");

    a_carry_shift: assert property ((alu_req.en && !reg_wr.en && alu_req.op == CRBA_OP_SHR) |=>
        st_ff.condition_code_byte[`CRBA_CCR_C] == $past(st_ff.acc[0]))
        else $error("shift carry mismatch");

    a_ip_advance: assert property ((ip_advance && !reg_wr.en) |=>
        instruction_pointer == $past(st_ff.ip) + 16'h0001)
        else $error("instruction pointer did not advance");

    a_mirror_read: assert property ((avs_read && avs_waitrequest && bus_idx == `CRBA_IDX_MIRROR) |=>
        !avs_waitrequest && avs_readdata == {24'h000000, $past(st_ff.rbp), $past(st_ff.dbf)})
        else $error("bank mirror read wrong");

endmodule : crba_core
`default_nettype wire

// ---- design/crba_defines.svh ----
// Constants for the CPU register bank and addressing block
`ifndef CRBA_DEFINES_SVH
`define CRBA_DEFINES_SVH

// Register indices; byte address is four times the index
`define CRBA_IDX_IP      9'h000
`define CRBA_IDX_ACC     9'h001
`define CRBA_IDX_TMP     9'h002
`define CRBA_IDX_INDEX   9'h003
`define CRBA_IDX_EP      9'h004
`define CRBA_IDX_SP      9'h005
`define CRBA_IDX_PSW     9'h006
`define CRBA_IDX_MIRROR  9'h078

// General-purpose register page and direct window base
`define CRBA_GP_PAGE     8'h01
`define CRBA_DIR_BASE    16'h0080

// Condition code byte bit positions
`define CRBA_CCR_H       7
`define CRBA_CCR_I       6
`define CRBA_CCR_IL_HI   5
`define CRBA_CCR_IL_LO   4
`define CRBA_CCR_N       3
`define CRBA_CCR_Z       2
`define CRBA_CCR_V       1
`define CRBA_CCR_C       0

// Reset values
`define CRBA_CCR_RST     8'h30
`define CRBA_RBP_RST     5'h00
`define CRBA_DBF_RST     3'h0
`define CRBA_IP_RST      16'h0000
`define CRBA_WORD_RST    16'h0000

`endif

// ---- design/crba_pkg.sv ----
// Types shared by the CPU register bank and addressing block
package crba_pkg;

    typedef enum logic [6:0] {
        CRBA_SEL_IP    = 7'h01,
        CRBA_SEL_ACC   = 7'h02,
        CRBA_SEL_TMP   = 7'h04,
        CRBA_SEL_INDEX = 7'h08,
        CRBA_SEL_EP    = 7'h10,
        CRBA_SEL_SP    = 7'h20,
        CRBA_SEL_PSW   = 7'h40
    } crba_reg_sel_type;

    typedef enum logic [3:0] {
        CRBA_OP_ADD = 4'h1,
        CRBA_OP_SUB = 4'h2,
        CRBA_OP_SHL = 4'h4,
        CRBA_OP_SHR = 4'h8
    } crba_alu_op_type;

    typedef enum logic [1:0] {
        CRBA_BUS_IDLE = 2'h1,
        CRBA_BUS_ACK  = 2'h2
    } crba_bus_state_type;

    typedef struct packed {
        logic             en;
        crba_reg_sel_type sel;
        logic [15:0]      data;
    } crba_reg_wr_type;

    typedef struct packed {
        logic            en;
        crba_alu_op_type op;
        logic            byte_mode;
    } crba_alu_req_type;

    typedef struct packed {
        logic [15:0] res;
        logic        h;
        logic        n;
        logic        z;
        logic        v;
        logic        c;
    } crba_alu_type;

    typedef struct packed {
        crba_bus_state_type bus;
        logic               waitreq;
        logic [31:0]        rdata;
        logic [15:0]        ip;
        logic [15:0]        acc;
        logic [15:0]        tmp;
        logic [15:0]        index;
        logic [15:0]        ep;
        logic [15:0]        sp;
        logic [4:0]         rbp;
        logic [2:0]         dbf;
        logic [7:0]         condition_code_byte;
        logic [15:0]        gp_addr;
        logic               gp_vld;
        logic [15:0]        dir_addr;
        logic               dir_vld;
        logic [15:0]        idx_addr;
        logic               idx_vld;
        logic               irq_take;
    } crba_state_type;

endpackage : crba_pkg

// ---- sim/crba_core_tb.sv ----
// Self-checking bench for the CPU register bank and addressing core
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module crba_core_tb
    import crba_pkg::*;
;
    logic             clock, rst_n, avs_read, avs_write, avs_waitrequest, ip_advance, gp_req, dir_req, idx_req;
    logic             irq_req, gp_addr_valid, dir_valid, idx_valid, irq_take;
    logic [10:0]      avs_address;
    logic [31:0]      avs_writedata, avs_readdata, rdata;
    logic [3:0]       avs_byteenable;
    crba_reg_wr_type  reg_wr;
    crba_alu_req_type alu_req;
    logic [2:0]       gp_opcode_bits;
    logic [7:0]       dir_addr, idx_disp;
    logic [1:0]       irq_level;
    logic [15:0]      gp_addr, dir_mapped, idx_addr, instruction_pointer, accumulator, temp_accumulator;
    logic [15:0]      index_reg, extra_pointer, stack_pointer, program_status_word;
    int               err_count, checks, cycles;

    crba_core crba_core_inst (.clock, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .reg_wr, .ip_advance, .alu_req, .gp_req,
        .gp_opcode_bits, .dir_req, .dir_addr, .idx_req, .idx_disp, .irq_req, .irq_level, .gp_addr,
        .gp_addr_valid, .dir_mapped, .dir_valid, .idx_addr, .idx_valid, .irq_take, .instruction_pointer,
        .accumulator, .temp_accumulator, .index_reg, .extra_pointer, .stack_pointer, .program_status_word);
    crba_dec_model crba_dec_model_inst (.clock, .reg_wr, .ip_advance, .alu_req, .gp_req, .gp_opcode_bits,
        .dir_req, .dir_addr, .idx_req, .idx_disp, .irq_req, .irq_level);

    always #10 clock = ~clock;

    task automatic complete_run;
        $display("checks=%0d mismatches=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run

    // Sized well above the few hundred cycles the tests need
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            complete_run();
        end
    end

    task automatic bus(input logic w, input logic [10:0] a, input logic [31:0] d, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge clock);
        {avs_address, avs_read, avs_write, avs_writedata, avs_byteenable} <= {a, ~w, w, d, be};
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (n == 20) err_count++;
        rdata = avs_readdata;
        {avs_read, avs_write} <= 2'b00;
    endtask : bus

    task automatic alu_case(crba_alu_op_type op, logic bm, logic [15:0] a, b, ea, logic [3:0] ef);
        crba_dec_model_inst.put_reg(CRBA_SEL_ACC, a);
        crba_dec_model_inst.put_reg(CRBA_SEL_TMP, b);
        crba_dec_model_inst.alu(op, bm);
        #1;
        `CHK(accumulator, ea)
        `CHK(program_status_word[3:0], ef)
    endtask : alu_case

    task automatic test_regs;
        bus(1'b0, 11'h018, 32'h0, 4'hF);
        `CHK(rdata, 32'h0000_0030)
        `CHK(irq_take, 1'b0)
        bus(1'b1, 11'h00C, 32'h0000_ABCD, 4'hF);
        bus(1'b1, 11'h010, 32'h0000_5A5A, 4'hF);
        bus(1'b1, 11'h014, 32'h0000_FFFE, 4'hF);
        bus(1'b1, 11'h000, 32'h0000_1234, 4'hF);
        bus(1'b1, 11'h00C, 32'hFFFF_00EE, 4'h1);
        bus(1'b1, 11'h040, 32'h0000_7777, 4'hF);
        bus(1'b0, 11'h040, 32'h0, 4'hF);
        `CHK(rdata, 32'h0)
        bus(1'b0, 11'h00C, 32'h0, 4'hF);
        `CHK(rdata, 32'h0000_ABEE)
        `CHK(index_reg, 16'hABEE)
        `CHK({extra_pointer, stack_pointer}, 32'h5A5A_FFFE)
        crba_dec_model_inst.req(3'h0, 8'h00);
        #1;
        `CHK(instruction_pointer, 16'h1235)
        crba_dec_model_inst.put_reg(CRBA_SEL_TMP, 16'h7FFE);
        bus(1'b0, 11'h008, 32'h0, 4'hF);
        `CHK(rdata, 32'h0000_7FFE)
        `CHK(temp_accumulator, 16'h7FFE)
        crba_dec_model_inst.put_reg(CRBA_SEL_INDEX, 16'h2468);
        crba_dec_model_inst.put_reg(CRBA_SEL_EP, 16'h1357);
        crba_dec_model_inst.put_reg(CRBA_SEL_SP, 16'h0FFE);
        crba_dec_model_inst.put_reg(CRBA_SEL_IP, 16'h4000);
        crba_dec_model_inst.put_reg(CRBA_SEL_PSW, 16'hA830);
        #1;
        `CHK({index_reg, extra_pointer, stack_pointer}, 48'h2468_1357_0FFE)
        `CHK({instruction_pointer, program_status_word}, 32'h4000_A830)
        $display("test_regs done");
    endtask : test_regs

    task automatic test_alu;
        alu_case(CRBA_OP_ADD, 1'b1, 16'h12FF, 16'h0001, 16'h1200, 4'h5);
        alu_case(CRBA_OP_ADD, 1'b1, 16'h007F, 16'h0001, 16'h0080, 4'hA);
        alu_case(CRBA_OP_SUB, 1'b1, 16'h0000, 16'h0001, 16'h00FF, 4'h9);
        alu_case(CRBA_OP_SHL, 1'b1, 16'h0081, 16'h0000, 16'h0002, 4'h1);
        alu_case(CRBA_OP_SHR, 1'b1, 16'h0001, 16'h0000, 16'h0000, 4'h5);
        alu_case(CRBA_OP_ADD, 1'b0, 16'h7FFF, 16'h0001, 16'h8000, 4'hA);
        alu_case(CRBA_OP_SUB, 1'b0, 16'h8000, 16'h0100, 16'h7F00, 4'h2);
        alu_case(CRBA_OP_SHL, 1'b0, 16'h8001, 16'h0000, 16'h0002, 4'h1);
        alu_case(CRBA_OP_SHR, 1'b0, 16'h8001, 16'h0000, 16'h4000, 4'h1);
        $display("test_alu done");
    endtask : test_alu

    task automatic test_addr;
        for (int d = 0; d < 8; d++) begin
            bus(1'b1, 11'h018, {16'h0, 5'h15, 3'(d), 8'h30}, 4'hF);
            crba_dec_model_inst.req(3'h2, 8'h85);
            #1;
            `CHK({dir_valid, dir_mapped}, {1'b1, 16'h0085 + 16'(d * 128)})
            crba_dec_model_inst.req(3'h2, 8'h7F);
            #1;
            `CHK(dir_mapped, 16'h007F)
            bus(1'b0, 11'h1E0, 32'h0, 4'hF);
            `CHK(rdata[7:0], {5'h15, 3'(d)})
            `CHK(program_status_word[15:8], {5'h15, 3'(d)})
            crba_dec_model_inst.req(3'h1, 8'(d));
            #1;
            `CHK({gp_addr_valid, gp_addr}, {1'b1, 8'h01, 5'h15, 3'(d)})
        end
        @(posedge clock);
        #1;
        `CHK(gp_addr_valid, 1'b0)
        bus(1'b1, 11'h018, 32'h0000_F830, 4'hF);
        crba_dec_model_inst.req(3'h1, 8'h07);
        #1;
        `CHK(gp_addr, 16'h01FF)
        bus(1'b1, 11'h00C, 32'h0000_1000, 4'hF);
        crba_dec_model_inst.req(3'h3, 8'hF0);
        #1;
        `CHK({idx_valid, idx_addr}, {1'b1, 16'h0FF0})
        $display("test_addr done");
    endtask : test_addr

    task automatic test_irq;
        logic [7:0] cc [6] = '{8'h30, 8'h60, 8'h60, 8'h70, 8'h70, 8'h40};
        logic [1:0] lv [6] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3, 2'h0};
        logic       tk [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, 11'h018, {24'h0, cc[i]}, 4'hF);
            crba_dec_model_inst.req(3'h4, {6'h0, lv[i]});
            #1;
            `CHK(irq_take, tk[i])
        end
        $display("test_irq done");
    endtask : test_irq

    // Mirror write, low-byte status write, then a reset in mid-run
    task automatic test_reset;
        bus(1'b1, 11'h1E0, 32'h0000_00FF, 4'h1);
        bus(1'b1, 11'h018, 32'h0000_007F, 4'h1);
        #1;
        `CHK(program_status_word, 16'hFF7F)
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        repeat (4) @(posedge clock);
        #1;
        `CHK(program_status_word, 16'h0030)
        bus(1'b0, 11'h1E0, 32'h0, 4'hF);
        `CHK(rdata, 32'h0)
        $display("test_reset done");
    endtask : test_reset

    initial begin
        {clock, rst_n, avs_address, avs_read, avs_write, avs_writedata, avs_byteenable} = '0;
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        repeat (4) @(posedge clock);
        test_regs();
        test_alu();
        test_addr();
        test_irq();
        test_reset();
        complete_run();
    end
endmodule : crba_core_tb
`default_nettype wire

// ---- sim/crba_dec_model.sv ----
// Decoder and arithmetic unit model driving the core's request ports
`timescale 1ns/10ps
`default_nettype none
module crba_dec_model
    import crba_pkg::*;
(
    // Clock
    input  wire logic            clock,
    // Requests toward the core
    output var crba_reg_wr_type  reg_wr,
    output var logic             ip_advance,
    output var crba_alu_req_type alu_req,
    output var logic             gp_req,
    output var logic [2:0]       gp_opcode_bits,
    output var logic             dir_req,
    output var logic [7:0]       dir_addr,
    output var logic             idx_req,
    output var logic [7:0]       idx_disp,
    output var logic             irq_req,
    output var logic [1:0]       irq_level
);
    initial begin
        {reg_wr, ip_advance, alu_req, gp_req, gp_opcode_bits, dir_req, dir_addr, idx_req, idx_disp} = '0;
        {irq_req, irq_level} = '0;
    end

    // Register data, opcode bits, direct address and displacement flip once the strobe drops, so stale values never look valid
    task automatic drop;
        @(posedge clock);
        {reg_wr.en, ip_advance, alu_req.en, gp_req, dir_req, idx_req, irq_req} <= '0;
        reg_wr.data <= ~reg_wr.data;
        {gp_opcode_bits, dir_addr, idx_disp} <= ~{gp_opcode_bits, dir_addr, idx_disp};
    endtask : drop

    task automatic put_reg(input crba_reg_sel_type s, input logic [15:0] d);
        @(posedge clock);
        reg_wr <= '{1'b1, s, d};
        drop();
    endtask : put_reg

    task automatic alu(input crba_alu_op_type op, input logic bm);
        @(posedge clock);
        alu_req <= '{1'b1, op, bm};
        drop();
    endtask : alu

    task automatic req(input logic [2:0] k, input logic [7:0] v);
        @(posedge clock);
        case (k)
            3'h0: {ip_advance} <= 1'b1;
            3'h1: {gp_req, gp_opcode_bits} <= {1'b1, v[2:0]};
            3'h2: {dir_req, dir_addr} <= {1'b1, v};
            3'h3: {idx_req, idx_disp} <= {1'b1, v};
            default: {irq_req, irq_level} <= {1'b1, v[1:0]};
        endcase
        drop();
    endtask : req
endmodule : crba_dec_model
`default_nettype wire
